// *** rtl/bsl_regs.svh ***
// Purpose: register offsets, field positions and reset values of the strap latch
// Assumes: included by bare name from the design and bench modules
// Notes:   definitions only
`ifndef BSL_REGS_SVH
`define BSL_REGS_SVH

// ==========================================================================
// register offsets
`define BSL_ADDR_W        8
`define BSL_OFF_STRAP     8'h00
`define BSL_OFF_CTRL      8'h04
`define BSL_OFF_STATUS    8'h08
`define BSL_OFF_PINS      8'h0c

// ==========================================================================
// strap word layout
`define BSL_STRAP_W       5
`define BSL_BIT_LDO       0
`define BSL_BIT_SEL       1
`define BSL_BIT_AUX       2
`define BSL_BIT_LOG       3
`define BSL_BIT_SDIO      4
`define BSL_PULL_UP_MASK  5'h1a
`define BSL_STRAP_RST     5'h1a
// edges after reset release until the pad synchroniser holds real levels
`define BSL_FILL_N        2

// ==========================================================================
// override control layout
`define BSL_CTRL_W        5
`define BSL_CTRL_RST      5'h00
`define BSL_CTRL_LDO_EN   0
`define BSL_CTRL_LDO_1V8  1
`define BSL_CTRL_SDIO_EN  2
`define BSL_CTRL_SDIO_IN  3
`define BSL_CTRL_SDIO_OUT 4

// ==========================================================================
// status layout
`define BSL_STAT_RUN      0
`define BSL_STAT_BOOT_LO  1
`define BSL_STAT_BOOT_HI  2
`define BSL_STAT_1V8      3
`define BSL_STAT_LOG      4
`define BSL_STAT_SDIO_IN  5
`define BSL_STAT_SDIO_OUT 6

`endif

// *** rtl/bsl_pkg.sv ***
// Purpose: types shared by the strap latch and its bench
// Assumes: nothing
// Notes:   constants live in bsl_regs.svh
package bsl_pkg;

    // ======================================================================
    // boot source decoded from the strap word
    typedef enum logic [1:0] {
        BSL_BOOT_SPI,
        BSL_BOOT_DOWNLOAD,
        BSL_BOOT_UNDEF
    } bsl_boot_t;

    // ======================================================================
    // block state: held in reset or running
    typedef enum logic {
        BSL_ST_HOLD,
        BSL_ST_RUN
    } bsl_state_t;

endpackage

// *** rtl/bsl_sync.sv ***
// Purpose: two-stage synchroniser for the strap pad inputs
// Assumes: one clock, asynchronous active-low reset
// Notes:   only the second stage may be read outside
`timescale 1ns/1ps
module bsl_sync #(
    parameter int          WIDTH   = 5,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule // bsl_sync

// *** rtl/bsl_top.sv ***
// Purpose: latch five configuration straps at reset release and decode them
// Assumes: all inputs synchronous to clk except the strap pads, which are
//          synchronised here; register reads answer one cycle later
// Notes:   pads are split into input, output and output enable; the pulls
//          are requested through pull_en and pull_up
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "bsl_regs.svh"

// What this block does
// RULE_01: five strap pins form five latched bits
// RULE_02: software reads latched bits, not live pins
// RULE_03: straps sampled during every system reset
// RULE_04: captured bits stay fixed until next reset
// RULE_05: weak pulls enabled while reset is active
// RULE_06: pins return to normal function after reset
// RULE_07: ldo strap selects 3.3V or 1.8V
// RULE_08: boot select high SPI, both low download
// RULE_09: log strap enables boot log on uart0_transmit
// RULE_10: log and sdio straps pick SDIO edges
// RULE_11: firmware bits override supply and SDIO timing
// RULE_12: outside drives straps and holds until sampled
// RULE_13: enable high runs, low holds in reset
// RULE_14: capture at reset release, then drop pulls
// RULE_15: decoded outputs valid from first cycle after
module bsl_top
    import bsl_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic                    enable,
    input  wire logic [`BSL_STRAP_W-1:0] strap_pin_in,
    output logic      [`BSL_STRAP_W-1:0] strap_pin_out,
    output logic      [`BSL_STRAP_W-1:0] strap_pin_oe,
    output logic      [`BSL_STRAP_W-1:0] pull_en,
    output logic      [`BSL_STRAP_W-1:0] pull_up,
    input  wire logic [`BSL_STRAP_W-1:0] func_out,
    input  wire logic [`BSL_STRAP_W-1:0] func_oe,
    output logic      [`BSL_STRAP_W-1:0] func_in,
    input  wire logic [`BSL_ADDR_W-1:0]  reg_addr,
    input  wire logic [DATA_W-1:0]       reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [DATA_W-1:0]       reg_rdata,
    output logic                         strap_valid,
    output logic      [`BSL_STRAP_W-1:0] strap_bits,
    output bsl_boot_t                    boot_mode,
    output logic                         flash_io_1v8,
    output logic                         boot_log_en,
    output logic                         sdio_in_rising,
    output logic                         sdio_out_rising
);

    // ======================================================================
    // decode helpers

    // boot source from a strap word; select low with aux high is undefined
    function automatic bsl_boot_t boot_decode(
        input logic [`BSL_STRAP_W-1:0] b
    );
        bsl_boot_t m;
        if (b[`BSL_BIT_SEL]) begin
            m = BSL_BOOT_SPI;
        end else if (!b[`BSL_BIT_AUX]) begin
            m = BSL_BOOT_DOWNLOAD;
        end else begin
            m = BSL_BOOT_UNDEF;
        end
        return m;
    endfunction

    // sdio edges from a strap word: [1] input rising, [0] output rising
    function automatic logic [1:0] sdio_decode(
        input logic [`BSL_STRAP_W-1:0] b
    );
        return {b[`BSL_BIT_LOG], b[`BSL_BIT_SDIO]};
    endfunction

    // pad-side word passed only while running, zero in hold
    function automatic logic [`BSL_STRAP_W-1:0] run_gate(
        input logic [`BSL_STRAP_W-1:0] w,
        input logic                    run
    );
        return w & {`BSL_STRAP_W{run}};
    endfunction

    // ======================================================================
    // declarations

    logic [`BSL_STRAP_W-1:0] pins_sync;
    logic [`BSL_FILL_N-1:0]  fill_q;
    logic [`BSL_FILL_N-1:0]  fill_d;
    bsl_state_t              state_q;
    bsl_state_t              state_d;
    logic [`BSL_STRAP_W-1:0] strap_q;
    logic [`BSL_STRAP_W-1:0] strap_d;
    logic                    valid_q;
    logic [`BSL_CTRL_W-1:0]  ctrl_q;
    logic [`BSL_CTRL_W-1:0]  ctrl_d;
    logic [`BSL_STRAP_W-1:0] pad_out_q;
    logic [`BSL_STRAP_W-1:0] pad_oe_q;
    logic [`BSL_STRAP_W-1:0] pull_en_q;
    logic [`BSL_STRAP_W-1:0] pull_up_q;
    logic [`BSL_STRAP_W-1:0] func_in_q;
    logic [DATA_W-1:0]       rdata_q;
    logic [DATA_W-1:0]       rdata_d;
    // decoded settings, one flop each except boot_q, which takes two
    bsl_boot_t               boot_q;
    logic                    ldo_1v8_q;
    logic                    log_en_q;
    logic                    sdio_in_q;
    logic                    sdio_out_q;

    // ======================================================================
    // pad input synchroniser
    // its reset value is the pull pattern, so reset and hold look alike
    bsl_sync #(
        .WIDTH   (`BSL_STRAP_W),
        .RST_VAL (`BSL_STRAP_RST)
    ) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      (strap_pin_in),
        .q      (pins_sync)
    );

    // ======================================================================
    // synchroniser fill

    // the synchroniser shows its reset value for two edges after release;
    // a capture before it fills would latch the defaults, not the pads
    wire sync_full = fill_q[`BSL_FILL_N-1];

    assign fill_d = {fill_q[`BSL_FILL_N-2:0], 1'b1};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fill_q <= '0;
        end else begin
            fill_q <= fill_d;
        end
    end

    // ======================================================================
    // reset sequencing

    // enable low acts as a synchronous reset back to hold
    wire in_hold  = (state_q == BSL_ST_HOLD);
    wire running  = (state_q == BSL_ST_RUN);
    wire capture  = in_hold && enable && sync_full; // RULE_14
    wire drop_run = running && !enable;   // RULE_13

    always_comb begin
        state_d = state_q;
        case (state_q)
            BSL_ST_HOLD: begin
                if (capture) begin
                    state_d = BSL_ST_RUN; // RULE_13
                end
            end
            BSL_ST_RUN: begin
                if (!enable) begin
                    state_d = BSL_ST_HOLD; // RULE_13
                end
            end
            default: begin
                state_d = BSL_ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= BSL_ST_HOLD;
        end else begin
            state_q <= state_d;
        end
    end

    // ======================================================================
    // strap latch

    // synchronised pins are taken only on the release edge
    assign strap_d = capture ? pins_sync : strap_q; // RULE_03 RULE_04

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            strap_q <= `BSL_STRAP_RST;
            valid_q <= 1'b0;
        end else begin
            strap_q <= strap_d; // RULE_01
            // valid tracks the state register one for one
            valid_q <= running ? !drop_run : capture;
        end
    end

    // ======================================================================
    // firmware override control

    wire sel_strap  = (reg_addr == `BSL_OFF_STRAP);
    wire sel_ctrl   = (reg_addr == `BSL_OFF_CTRL);
    wire sel_status = (reg_addr == `BSL_OFF_STATUS);
    wire sel_pins   = (reg_addr == `BSL_OFF_PINS);
    // firmware can write the overrides only once the straps are latched
    wire ctrl_wr    = reg_wr && sel_ctrl && running;

    // overrides are cleared by any reset so a new boot starts from straps
    assign ctrl_d = in_hold ? `BSL_CTRL_RST
                  : ctrl_wr ? reg_wdata[`BSL_CTRL_W-1:0]
                  : ctrl_q; // RULE_11

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= `BSL_CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ======================================================================
    // decoded settings

    // the source word bypasses the latch on the capture edge so that the
    // decoded outputs change together with the strap bits
    wire [`BSL_STRAP_W-1:0] src_bits = capture ? pins_sync : strap_q; // RULE_15
    wire [1:0]              src_sdio = sdio_decode(src_bits);          // RULE_10

    wire ovr_ldo  = ctrl_d[`BSL_CTRL_LDO_EN];
    wire ovr_sdio = ctrl_d[`BSL_CTRL_SDIO_EN];

    wire       ldo_1v8_d = ovr_ldo ? ctrl_d[`BSL_CTRL_LDO_1V8]
                                   : src_bits[`BSL_BIT_LDO]; // RULE_07 RULE_11
    wire       sdio_in_d = ovr_sdio ? ctrl_d[`BSL_CTRL_SDIO_IN]
                                    : src_sdio[1]; // RULE_10 RULE_11
    wire       sdio_out_d = ovr_sdio ? ctrl_d[`BSL_CTRL_SDIO_OUT]
                                     : src_sdio[0]; // RULE_10 RULE_11
    wire       log_en_d  = src_bits[`BSL_BIT_LOG]; // RULE_09
    bsl_boot_t boot_d;
    assign     boot_d    = boot_decode(src_bits); // RULE_08

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            boot_q     <= BSL_BOOT_SPI;
            ldo_1v8_q  <= 1'b0;
            log_en_q   <= 1'b0;
            sdio_in_q  <= 1'b0;
            sdio_out_q <= 1'b0;
        end else begin
            boot_q     <= boot_d;
            ldo_1v8_q  <= ldo_1v8_d;
            log_en_q   <= log_en_d;
            sdio_in_q  <= sdio_in_d;
            sdio_out_q <= sdio_out_d;
        end
    end

    // ======================================================================
    // pad control

    // in hold the pads float with their weak pulls; once running the
    // normal-function logic owns them
    wire                    run_d    = capture || (running && !drop_run);
    wire [`BSL_STRAP_W-1:0] run_mask = {`BSL_STRAP_W{run_d}};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pad_out_q <= '0;
            pad_oe_q  <= '0;
            pull_en_q <= '1;
            pull_up_q <= `BSL_PULL_UP_MASK;
            func_in_q <= '0;
        end else begin
            pad_out_q <= run_gate(func_out, run_d); // RULE_06
            pad_oe_q  <= run_gate(func_oe, run_d);  // RULE_06
            pull_en_q <= ~run_mask;           // RULE_05 RULE_14
            pull_up_q <= `BSL_PULL_UP_MASK;   // RULE_05
            func_in_q <= run_gate(pins_sync, run_d); // RULE_06
        end
    end

    // ======================================================================
    // register read port

    logic [DATA_W-1:0] status_word;

    always_comb begin
        status_word                       = '0;
        status_word[`BSL_STAT_RUN]        = valid_q;
        status_word[`BSL_STAT_BOOT_HI:`BSL_STAT_BOOT_LO] = boot_q;
        status_word[`BSL_STAT_1V8]        = ldo_1v8_q;
        status_word[`BSL_STAT_LOG]        = log_en_q;
        status_word[`BSL_STAT_SDIO_IN]    = sdio_in_q;
        status_word[`BSL_STAT_SDIO_OUT]   = sdio_out_q;
    end

    // strap offset shows the latch; the live pads have an offset of their own
    // unmapped offsets and idle cycles read as zero
    always_comb begin
        rdata_d = '0;
        if (reg_rd) begin
            if (sel_strap) begin
                rdata_d[`BSL_STRAP_W-1:0] = strap_q; // RULE_02
            end else if (sel_ctrl) begin
                rdata_d[`BSL_CTRL_W-1:0] = ctrl_q;
            end else if (sel_status) begin
                rdata_d = status_word;
            end else if (sel_pins) begin
                rdata_d[`BSL_STRAP_W-1:0] = pins_sync;
            end else begin
                rdata_d = '0;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ======================================================================
    // outputs

    // each output is driven straight from its flop
    assign strap_pin_out   = pad_out_q;
    assign strap_pin_oe    = pad_oe_q;
    assign pull_en         = pull_en_q;
    assign pull_up         = pull_up_q;
    assign func_in         = func_in_q;
    assign reg_rdata       = rdata_q;
    assign strap_valid     = valid_q;
    assign strap_bits      = strap_q;
    assign boot_mode       = boot_q;
    assign flash_io_1v8    = ldo_1v8_q;
    assign boot_log_en     = log_en_q;
    assign sdio_in_rising  = sdio_in_q;
    assign sdio_out_rising = sdio_out_q;

endmodule // bsl_top

// *** testbench/bsl_top_props.sv ***
// Purpose: port assertions for the strap latch
// Assumes: one clock, resetn active low
// Notes:   bound to bsl_top
`timescale 1ns/1ps
`include "bsl_regs.svh"
module bsl_top_props
    import bsl_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input wire logic              clk,
    input wire logic              resetn,
    input wire logic              enable,
    input wire logic [4:0]        strap_pin_in,
    input wire logic [4:0]        strap_pin_out,
    input wire logic [4:0]        strap_pin_oe,
    input wire logic [4:0]        pull_en,
    input wire logic [4:0]        pull_up,
    input wire logic [4:0]        func_out,
    input wire logic [4:0]        func_oe,
    input wire logic [4:0]        func_in,
    input wire logic [7:0]        reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              strap_valid,
    input wire logic [4:0]        strap_bits,
    input wire bsl_boot_t         boot_mode,
    input wire logic              flash_io_1v8,
    input wire logic              boot_log_en,
    input wire logic              sdio_in_rising,
    input wire logic              sdio_out_rising
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // ======================================================================
    // assertions
    chk_pull_hold: assert property (!enable |=> pull_en == 5'h1f)
        else $error("pulls not on while held");
    chk_pull_dir: assert property (pull_up == 5'h1a)
        else $error("pull direction wrong");
    chk_valid_pulls: assert property (strap_valid |-> pull_en == 5'h00)
        else $error("pulls on while running");
    chk_strap_hold: assert property (strap_valid && $past(strap_valid) |-> $stable(strap_bits))
        else $error("strap word changed while running");
    chk_capture_pins: assert property ($rose(strap_valid) |-> strap_bits == $past(strap_pin_in, 3))
        else $error("captured word differs from pins");
    chk_pad_follow: assert property (strap_valid && $past(strap_valid) |->
        strap_pin_oe == $past(func_oe) && strap_pin_out == $past(func_out))
        else $error("pads do not follow normal function");
    chk_boot_decode: assert property (strap_valid |-> boot_mode == (strap_bits[1] ? BSL_BOOT_SPI :
        (strap_bits[2] ? BSL_BOOT_UNDEF : BSL_BOOT_DOWNLOAD)))
        else $error("boot mode decode wrong");
    chk_cap_decode: assert property ($rose(strap_valid) |-> flash_io_1v8 == strap_bits[0] &&
        boot_log_en == strap_bits[3] && sdio_in_rising == strap_bits[3] &&
        sdio_out_rising == strap_bits[4])
        else $error("decoded outputs wrong at capture");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data outside answer cycle");
    chk_ldo_override: assert property (reg_wr && enable && strap_valid && reg_addr == 8'h04 &&
        reg_wdata[0] |=> flash_io_1v8 == $past(reg_wdata[1]))
        else $error("supply override not applied");

    cover property ($rose(strap_valid));
    cover property (reg_wr && reg_addr == 8'h04 && strap_valid);
    cover property (strap_valid && boot_mode == BSL_BOOT_UNDEF);
endmodule // bsl_top_props

bind bsl_top bsl_top_props #(.DATA_W(DATA_W)) bsl_top_props_inst (.clk(clk), .resetn(resetn),
    .enable(enable), .strap_pin_in(strap_pin_in), .strap_pin_out(strap_pin_out),
    .strap_pin_oe(strap_pin_oe), .pull_en(pull_en), .pull_up(pull_up), .func_out(func_out),
    .func_oe(func_oe), .func_in(func_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .strap_valid(strap_valid),
    .strap_bits(strap_bits), .boot_mode(boot_mode), .flash_io_1v8(flash_io_1v8),
    .boot_log_en(boot_log_en), .sdio_in_rising(sdio_in_rising),
    .sdio_out_rising(sdio_out_rising));

// *** testbench/bsl_pad_model.sv ***
// Purpose: board side of the strap pads: resistors or host GPIOs
// Assumes: design pad drive wins over the host
// Notes:   an undriven pad without pull toggles every cycle
`timescale 1ns/1ps
module bsl_pad_model (
    input  wire logic       clk,
    input  wire logic [4:0] drive_en,
    input  wire logic [4:0] drive_val,
    input  wire logic [4:0] pull_en,
    input  wire logic [4:0] pull_up,
    input  wire logic [4:0] pad_oe,
    input  wire logic [4:0] pad_out,
    output logic      [4:0] level
);
    logic [4:0] float_q = 5'h00;

    always @(posedge clk) float_q <= ~float_q;

    // host drive holds through capture; the bench then flips its value, not its enable
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            level[i] = pad_oe[i] ? pad_out[i] : drive_en[i] ? drive_val[i] :
                       pull_en[i] ? pull_up[i] : float_q[i];
        end
    end
endmodule // bsl_pad_model

// *** testbench/bsl_top_tb.sv ***
// Purpose: self-checking bench for the strap latch
// Assumes: registers per the design header
// Notes:   fixed-seed lfsr stimulus with corner straps
`timescale 1ns/1ps
`include "bsl_regs.svh"
module bsl_top_tb
    import bsl_pkg::*;
();
    logic        clk, resetn, enable, reg_wr, reg_rd;
    logic        strap_valid, f1v8, log_en, sd_in, sd_out;
    logic [4:0]  drv_en, drv_val, func_out, func_oe, en, v, s, ov, pm, pe;
    logic [4:0]  pin_lvl, pin_out, pin_oe, pull_en, pull_up, func_in, strap_bits;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rnd, rd_d;
    logic [4:0]  cv [6] = '{5'h00, 5'h1f, 5'h04, 5'h08, 5'h10, 5'h00};
    bsl_boot_t   boot_mode;
    int          errors = 0;
    int          n_tests = 0;

    bsl_top #(.DATA_W(32)) bsl_top_inst (.clk(clk), .resetn(resetn), .enable(enable),
        .strap_pin_in(pin_lvl), .strap_pin_out(pin_out), .strap_pin_oe(pin_oe),
        .pull_en(pull_en), .pull_up(pull_up), .func_out(func_out), .func_oe(func_oe),
        .func_in(func_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .strap_valid(strap_valid),
        .strap_bits(strap_bits), .boot_mode(boot_mode), .flash_io_1v8(f1v8),
        .boot_log_en(log_en), .sdio_in_rising(sd_in), .sdio_out_rising(sd_out));
    bsl_pad_model bsl_pad_model_inst (.clk(clk), .drive_en(drv_en), .drive_val(drv_val),
        .pull_en(pull_en), .pull_up(pull_up), .pad_oe(pin_oe), .pad_out(pin_out),
        .level(pin_lvl));

    // ======================================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [4:0] exp_strap(input logic [4:0] e, input logic [4:0] d);
        return (e & d) | (~e & 5'h1a);
    endfunction
    function automatic bsl_boot_t exp_boot(input logic [4:0] x);
        return x[1] ? BSL_BOOT_SPI : (x[2] ? BSL_BOOT_UNDEF : BSL_BOOT_DOWNLOAD);
    endfunction
    function automatic logic [31:0] exp_stat(input logic [4:0] x, input logic [4:0] o);
        return {25'h0, (o[2] ? o[4] : x[4]), (o[2] ? o[3] : x[3]), x[3],
                (o[0] ? o[1] : x[0]), exp_boot(x), 1'b1};
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_d = reg_rdata;
    endtask
    task automatic cap(input logic hard);
        @(posedge clk);
        enable <= 1'b0;
        resetn <= !hard;
        drv_en <= en;
        drv_val <= v;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check("pull_en", pull_en, 5'h1f);
        check("pull_up", pull_up, 5'h1a);
        check("pad_oe", pin_oe, 5'h00);
        check("valid", strap_valid, 1'b0);
        @(posedge clk);
        enable <= 1'b1;
        @(posedge clk);
        drv_val <= ~v;
        #1;
        check("valid", strap_valid, 1'b1);
        check("strap", strap_bits, s);
        check("pulls", pull_en, 5'h00);
        check("boot", boot_mode, exp_boot(s));
        check("1v8", f1v8, s[0]);
        check("log", log_en, s[3]);
        check("sdio", {sd_in, sd_out}, {s[3], s[4]});
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ======================================================================
    // clock, watchdog and tests
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        wrap_up();
    end
    initial begin
        resetn = 1'b0;
        enable = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        drv_en = 5'h00;
        drv_val = 5'h00;
        func_out = 5'h00;
        func_oe = 5'h00;
        rnd = 32'hf4a90c05;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 14; i++) begin
            rnd = lfsr(rnd);
            en = (i < 5) ? 5'h1f : (i == 5) ? 5'h00 : rnd[4:0];
            v = (i < 6) ? cv[i] : rnd[9:5];
            s = exp_strap(en, v);
            cap(i == 3 || i == 9);
            @(posedge clk);
            func_oe <= rnd[14:10];
            func_out <= rnd[19:15];
            drv_val <= rnd[24:20];
            repeat (2) @(posedge clk);
            #1;
            check("pad_oe", pin_oe, func_oe);
            check("pad_out", pin_out, func_out);
            check("held", strap_bits, s);
            wr(`BSL_OFF_STRAP, {27'h0, ~s});
            rd(`BSL_OFF_STRAP);
            check("strap_rd", rd_d, {27'h0, s});
            rd(8'h10);
            check("unmapped", rd_d, 32'h0);
            ov = rnd[29:25];
            wr(`BSL_OFF_CTRL, {27'h0, ov});
            check("ldo_ovr", f1v8, ov[0] ? ov[1] : s[0]);
            check("sdio_ovr", {sd_in, sd_out}, ov[2] ? {ov[3], ov[4]} : {s[3], s[4]});
            check("log_kept", log_en, s[3]);
            rd(`BSL_OFF_CTRL);
            check("ctrl_rd", rd_d, {27'h0, ov});
            rd(`BSL_OFF_STATUS);
            check("status_rd", rd_d, exp_stat(s, ov));
            pm = func_oe | drv_en;
            pe = (func_oe & func_out) | (~func_oe & drv_en & drv_val);
            rd(`BSL_OFF_PINS);
            check("pins_rd", rd_d & {27'h0, pm}, {27'h0, pe});
            check("func_in", func_in & pm, pe);
            $display("test %0d done", i);
        end
        // reset released with enable already high, as at power-on
        en = 5'h1f;
        v = 5'h05;
        s = exp_strap(en, v);
        @(posedge clk);
        resetn <= 1'b0;
        drv_en <= en;
        drv_val <= v;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        check("por_strap", strap_bits, s);
        check("por_valid", strap_valid, 1'b1);
        check("por_boot", boot_mode, exp_boot(s));
        $display("test power-on done");
        wrap_up();
    end
endmodule // bsl_top_tb
